// >>> hw/srf_defines.svh
// Constants of the shift, rotate and flag unit.
//
// Contract
// - I/O bit clear zeroes bit, two cycles
// - Left shift fills zero, sets Z C N V
// - Right shift fills zero, sets Z C N V
// - Rotate left through carry, sets flags
// - Rotate right through carry, sets flags
// - Arithmetic right shift keeps sign bit
// - Nibble swap, flags untouched, one cycle
// - Selected register bit copied to transfer flag
// - Transfer flag copied into selected bit
// - Interrupt enable flag set or cleared
// - Sign flag set alone, one cycle
// - Sign flag cleared alone, one cycle
// - Overflow flag set alone, one cycle
// - Overflow flag cleared alone, one cycle
// - Half carry set alone, one cycle
// - Half carry cleared alone, one cycle
// - Sleep request in one cycle, flags kept
// - Watchdog restart in one cycle, flags kept
// - Debug break for debug logic, flags kept
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH
`define SRF_FLAG_C 0
`define SRF_FLAG_Z 1
`define SRF_FLAG_N 2
`define SRF_FLAG_V 3
`define SRF_FLAG_S 4
`define SRF_FLAG_H 5
`define SRF_FLAG_T 6
`define SRF_FLAG_I 7
`define SRF_MSB 7
`define SRF_FLAGS_RESET 8'h00
`define SRF_BYTE_ZERO 8'h00
`define SRF_PAD_ZERO 24'h000000
`define SRF_WORD_ZERO 32'h00000000
`define SRF_OFS_FLAGS 12'h000
`define SRF_OFS_OPSTAT 12'h004
`endif

// >>> hw/srf_pkg.sv
// Types shared by the shift, rotate and flag unit.
package srf_pkg;
  // Operations that the decoder may issue.
  typedef enum logic [3:0] {
    OP_NOP, OP_IO_BIT_CLEAR, OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT,
    OP_NIBBLE_SWAP, OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_FLAG_SET, OP_FLAG_CLEAR, OP_SLEEP, OP_WATCHDOG_RESTART, OP_DEBUG_BREAK
  } srf_op_e;
  // One data byte.
  typedef logic [7:0] srf_byte_t;
  // Builds a one-hot mask for a bit index.
  function automatic srf_byte_t srf_bit_mask(input logic [2:0] sel);
    srf_bit_mask = srf_byte_t'(8'h01) << sel;
  endfunction : srf_bit_mask
endpackage : srf_pkg

// >>> hw/srf_link_if.sv
// Interface between the core of the unit, its shifter and its registers.
`timescale 1ns/1ps
`default_nettype none
interface srf_link_if;
  srf_pkg::srf_op_e  shiftOp;    // Operation under way.
  srf_pkg::srf_byte_t shiftIn;   // Destination operand.
  logic              carryIn;    // Carry before the operation.
  srf_pkg::srf_byte_t shiftOut;  // Shifted result.
  logic              zeroOut;    // Result is zero.
  logic              carryOut;   // Bit shifted out.
  logic              negOut;     // Result sign.
  logic              ovfOut;     // Sign xor carry.
  logic              regWrEn;    // Software writes the flags.
  srf_pkg::srf_byte_t regWrData; // Flag value written.
  srf_pkg::srf_byte_t flagsView; // Flags for reads.
  srf_pkg::srf_byte_t opStatView; // Operation status for reads.
  modport shifter (input shiftOp, shiftIn, carryIn,
                   output shiftOut, zeroOut, carryOut, negOut, ovfOut);
  modport regs (output regWrEn, regWrData, input flagsView, opStatView);
  modport core (output shiftOp, shiftIn, carryIn, flagsView, opStatView,
                input shiftOut, zeroOut, carryOut, negOut, ovfOut, regWrEn, regWrData);
endinterface : srf_link_if
`default_nettype wire

// >>> hw/srf_shifter.sv
// Combinational shifter, rotator and nibble swapper.
`timescale 1ns/1ps
`default_nettype none
`include "srf_defines.svh"
module srf_shifter (
  srf_link_if.shifter link
);
  // Forms the result and the bit that leaves the byte.
  always_comb begin
    link.shiftOut = link.shiftIn;
    link.carryOut = link.carryIn;
    unique case (link.shiftOp)
      srf_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        link.shiftOut = {link.shiftIn[`SRF_MSB-1:0], 1'b0};
        link.carryOut = link.shiftIn[`SRF_MSB];
      end
      srf_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        link.shiftOut = {1'b0, link.shiftIn[`SRF_MSB:1]};
        link.carryOut = link.shiftIn[0];
      end
      srf_pkg::OP_ROTATE_LEFT_CARRY: begin
        link.shiftOut = {link.shiftIn[`SRF_MSB-1:0], link.carryIn};
        link.carryOut = link.shiftIn[`SRF_MSB];
      end
      srf_pkg::OP_ROTATE_RIGHT_CARRY: begin
        link.shiftOut = {link.carryIn, link.shiftIn[`SRF_MSB:1]};
        link.carryOut = link.shiftIn[0];
      end
      srf_pkg::OP_ARITH_RIGHT_SHIFT: begin
        link.shiftOut = {link.shiftIn[`SRF_MSB], link.shiftIn[`SRF_MSB:1]};
        link.carryOut = link.shiftIn[0];
      end
      srf_pkg::OP_NIBBLE_SWAP: begin
        link.shiftOut = {link.shiftIn[3:0], link.shiftIn[`SRF_MSB:4]};
      end
      default: begin
        // Other operations pass the operand through unchanged.
        link.shiftOut = link.shiftIn;
      end
    endcase
    link.zeroOut = (link.shiftOut == `SRF_BYTE_ZERO);
    link.negOut  = link.shiftOut[`SRF_MSB];
    link.ovfOut  = link.shiftOut[`SRF_MSB] ^ link.carryOut;
  end
endmodule : srf_shifter
`default_nettype wire

// >>> hw/srf_apb_regs.sv
// APB slave for the flag and operation status registers.
`timescale 1ns/1ps
`default_nettype none
`include "srf_defines.svh"
module srf_apb_regs (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  srf_link_if.regs         link
);
  logic setupPhase; // Setup cycle of a transfer.
  logic mapped;     // Address hits a register.
  assign setupPhase = psel && !penable;
  assign mapped = (paddr == `SRF_OFS_FLAGS) || (paddr == `SRF_OFS_OPSTAT);
  // A write to the flags lands at the completing access edge.
  assign link.regWrEn = psel && penable && pready && pwrite && (paddr == `SRF_OFS_FLAGS);
  assign link.regWrData = pwdata[7:0];
  // No access waits, as pready comes from a flop set in the setup cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end
  // Read data and error are captured in the setup cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= `SRF_WORD_ZERO;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= !mapped;
      if (pwrite || !mapped) begin
        prdata <= `SRF_WORD_ZERO;
      end else if (paddr == `SRF_OFS_FLAGS) begin
        prdata <= {`SRF_PAD_ZERO, link.flagsView};
      end else begin
        prdata <= {`SRF_PAD_ZERO, link.opStatView};
      end
    end
  end
endmodule : srf_apb_regs
`default_nettype wire

// >>> hw/srf_shift_rotate_flag_unit.sv
// Top of the shift, rotate and flag unit of the core datapath.
`timescale 1ns/1ps
`default_nettype none
`include "srf_defines.svh"
module srf_shift_rotate_flag_unit (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic             opValid,
  input  wire srf_pkg::srf_op_e opCode,
  input  wire logic [2:0]       opBitSel,
  input  wire logic [2:0]       opFlagSel,
  input  wire logic [7:0]       regOperand,
  input  wire logic [7:0]       ioOperand,
  input  wire logic [5:0]       ioAddr,
  output var  logic             opReady,
  output var  logic             rfWrEn,
  output var  logic [7:0]       rfWrData,
  output var  logic             ioWrEn,
  output var  logic [5:0]       ioWrAddr,
  output var  logic [7:0]       ioWrData,
  output var  logic [7:0]       statusFlags,
  output var  logic             sleepReq,
  output var  logic             watchdogRestart,
  output var  logic             debugBreak
);
  // Two-state sequence for the I/O bit clear.
  typedef enum logic {ST_IDLE, ST_IO_WRITE} srf_state_e;

  srf_link_if link ();                 // Links the shifter and registers.
  srf_state_e         state_q;         // Sequencer state.
  logic               opReady_q;       // Ready for a new operation.
  logic               rfWrEn_q;        // Register file write strobe.
  srf_pkg::srf_byte_t rfWrData_q;      // Register file write data.
  logic               ioWrEn_q;        // I/O write strobe.
  logic [5:0]         ioWrAddr_q;      // I/O register address.
  srf_pkg::srf_byte_t ioWrData_q;      // I/O data with the bit cleared.
  srf_pkg::srf_byte_t flags_q;         // Status flags register.
  srf_pkg::srf_byte_t flags_d;         // Next value of the flags.
  logic               sleepReq_q;      // Sleep request pulse.
  logic               wdtRestart_q;    // Watchdog restart pulse.
  logic               debugBreak_q;    // Debug break pulse.
  srf_pkg::srf_op_e   lastOp_q;        // Last operation accepted.
  logic               opAccept;        // Operation taken this cycle.
  logic               rfWrite;         // Operation writes the register file.
  srf_pkg::srf_byte_t rfResult;        // Register file result.

  // The sub-blocks share the link interface.
  srf_shifter u_shifter (
    .link (link)
  );
  srf_apb_regs u_regs (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .link    (link)
  );

  // The shifter sees the operand and the carry held now.
  assign link.shiftOp    = opCode;
  assign link.shiftIn    = regOperand;
  assign link.carryIn    = flags_q[`SRF_FLAG_C];
  assign link.flagsView  = flags_q;
  assign link.opStatView = {3'b000, !opReady_q, lastOp_q};
  assign opAccept        = opValid && opReady_q;

  // Outputs come straight from flops.
  assign opReady         = opReady_q;
  assign rfWrEn          = rfWrEn_q;
  assign rfWrData        = rfWrData_q;
  assign ioWrEn          = ioWrEn_q;
  assign ioWrAddr        = ioWrAddr_q;
  assign ioWrData        = ioWrData_q;
  assign statusFlags     = flags_q;
  assign sleepReq        = sleepReq_q;
  assign watchdogRestart = wdtRestart_q;
  assign debugBreak      = debugBreak_q;

  // Picks the register file result and the next flags.
  always_comb begin
    rfWrite  = 1'b0;
    rfResult = link.shiftOut;
    // A software write is the base, so an operation in the same cycle wins.
    flags_d  = link.regWrEn ? link.regWrData : flags_q;
    if (opAccept) begin
      unique case (opCode)
        srf_pkg::OP_LOGICAL_LEFT_SHIFT, srf_pkg::OP_LOGICAL_RIGHT_SHIFT,
        srf_pkg::OP_ROTATE_LEFT_CARRY, srf_pkg::OP_ROTATE_RIGHT_CARRY,
        srf_pkg::OP_ARITH_RIGHT_SHIFT: begin
          rfWrite = 1'b1;
          flags_d[`SRF_FLAG_Z] = link.zeroOut;
          flags_d[`SRF_FLAG_C] = link.carryOut;
          flags_d[`SRF_FLAG_N] = link.negOut;
          flags_d[`SRF_FLAG_V] = link.ovfOut;
        end
        srf_pkg::OP_NIBBLE_SWAP: begin
          rfWrite = 1'b1;
        end
        srf_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
          flags_d[`SRF_FLAG_T] = regOperand[opBitSel];
        end
        srf_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
          rfWrite = 1'b1;
          rfResult = flags_q[`SRF_FLAG_T] ? (regOperand | srf_pkg::srf_bit_mask(opBitSel))
                                          : (regOperand & ~srf_pkg::srf_bit_mask(opBitSel));
        end
        srf_pkg::OP_FLAG_SET: begin
          flags_d[opFlagSel] = 1'b1;
        end
        srf_pkg::OP_FLAG_CLEAR: begin
          flags_d[opFlagSel] = 1'b0;
        end
        srf_pkg::OP_NOP, srf_pkg::OP_IO_BIT_CLEAR, srf_pkg::OP_SLEEP,
        srf_pkg::OP_WATCHDOG_RESTART, srf_pkg::OP_DEBUG_BREAK: begin
          // These leave the flags and the register file alone.
          rfWrite = 1'b0;
        end
        default: begin
          // An unused code is treated as no operation.
          rfWrite = 1'b0;
        end
      endcase
    end
  end

  // Sequencer: the I/O clear holds off new work for one extra cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= ST_IDLE;
      opReady_q <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (opAccept && (opCode == srf_pkg::OP_IO_BIT_CLEAR)) begin
            state_q   <= ST_IO_WRITE;
            opReady_q <= 1'b0;
          end
        end
        ST_IO_WRITE: begin
          state_q   <= ST_IDLE;
          opReady_q <= 1'b1;
        end
      endcase
    end
  end

  // I/O path: read value is masked in cycle one and written in cycle two.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ioWrEn_q   <= 1'b0;
      ioWrAddr_q <= '0;
      ioWrData_q <= `SRF_BYTE_ZERO;
    end else begin
      ioWrEn_q <= (state_q == ST_IO_WRITE);
      if (opAccept && (opCode == srf_pkg::OP_IO_BIT_CLEAR)) begin
        ioWrAddr_q <= ioAddr;
        ioWrData_q <= ioOperand & ~srf_pkg::srf_bit_mask(opBitSel);
      end
    end
  end

  // Register file write-back, one cycle after the operation is taken.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rfWrEn_q   <= 1'b0;
      rfWrData_q <= `SRF_BYTE_ZERO;
    end else begin
      rfWrEn_q <= rfWrite;
      if (rfWrite) begin
        rfWrData_q <= rfResult;
      end
    end
  end

  // Status flags register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= `SRF_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Control pulses to the sleep, watchdog and debug logic.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepReq_q   <= 1'b0;
      wdtRestart_q <= 1'b0;
      debugBreak_q <= 1'b0;
    end else begin
      sleepReq_q   <= opAccept && (opCode == srf_pkg::OP_SLEEP);
      wdtRestart_q <= opAccept && (opCode == srf_pkg::OP_WATCHDOG_RESTART);
      debugBreak_q <= opAccept && (opCode == srf_pkg::OP_DEBUG_BREAK);
    end
  end

  // Records the last accepted operation for status reads.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lastOp_q <= srf_pkg::OP_NOP;
    end else if (opAccept) begin
      lastOp_q <= opCode;
    end
  end

  // Checks below, all but a_io_clear and a_break, ignore cycles in which software writes the flags.
  logic cleanOp; // Operation taken with no software flag write.
  assign cleanOp = opAccept && !link.regWrEn;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  property p_io_clear;
    (opAccept && opCode == srf_pkg::OP_IO_BIT_CLEAR) |=> !opReady ##1
      (ioWrEn && ioWrData == ($past(ioOperand, 2) & ~srf_pkg::srf_bit_mask($past(opBitSel, 2))));
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("I/O bit clear wrong");

  property p_lsl;
    (cleanOp && opCode == srf_pkg::OP_LOGICAL_LEFT_SHIFT) |=> rfWrEn &&
      rfWrData == {$past(regOperand[6:0]), 1'b0} && statusFlags[`SRF_FLAG_C] == $past(regOperand[7]);
  endproperty
  a_lsl: assert property (p_lsl) else $error("Left shift wrong");

  property p_lsr;
    (cleanOp && opCode == srf_pkg::OP_LOGICAL_RIGHT_SHIFT) |=> rfWrEn &&
      rfWrData == {1'b0, $past(regOperand[7:1])} && statusFlags[`SRF_FLAG_C] == $past(regOperand[0]);
  endproperty
  a_lsr: assert property (p_lsr) else $error("Right shift wrong");

  property p_rol;
    (cleanOp && opCode == srf_pkg::OP_ROTATE_LEFT_CARRY) |=>
      rfWrData[0] == $past(flags_q[`SRF_FLAG_C]) && statusFlags[`SRF_FLAG_C] == $past(regOperand[7]);
  endproperty
  a_rol: assert property (p_rol) else $error("Rotate left wrong");

  property p_ror;
    (cleanOp && opCode == srf_pkg::OP_ROTATE_RIGHT_CARRY) |=>
      rfWrData[7] == $past(flags_q[`SRF_FLAG_C]) && statusFlags[`SRF_FLAG_C] == $past(regOperand[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("Rotate right wrong");

  property p_asr;
    (cleanOp && opCode == srf_pkg::OP_ARITH_RIGHT_SHIFT) |=>
      rfWrData == {$past(regOperand[7]), $past(regOperand[7:1])} &&
      statusFlags[`SRF_FLAG_Z] == (rfWrData == `SRF_BYTE_ZERO);
  endproperty
  a_asr: assert property (p_asr) else $error("Arithmetic shift wrong");

  property p_swap;
    (cleanOp && opCode == srf_pkg::OP_NIBBLE_SWAP) |=> rfWrEn && $stable(statusFlags) &&
      rfWrData == {$past(regOperand[3:0]), $past(regOperand[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("Nibble swap wrong");

  property p_bit_store;
    (cleanOp && opCode == srf_pkg::OP_BIT_TO_TRANSFER_FLAG) |=>
      statusFlags == (($past(flags_q) & ~srf_pkg::srf_bit_mask(3'(`SRF_FLAG_T))) |
      ({7'h00, $past(regOperand[opBitSel])} << `SRF_FLAG_T));
  endproperty
  a_bit_store: assert property (p_bit_store) else $error("Bit store wrong");

  property p_bit_load;
    (cleanOp && opCode == srf_pkg::OP_TRANSFER_FLAG_TO_BIT) |=> rfWrEn && $stable(statusFlags) &&
      rfWrData[$past(opBitSel)] == statusFlags[`SRF_FLAG_T];
  endproperty
  a_bit_load: assert property (p_bit_load) else $error("Bit load wrong");

  property p_flag_set;
    (cleanOp && opCode == srf_pkg::OP_FLAG_SET) |=>
      statusFlags == ($past(flags_q) | srf_pkg::srf_bit_mask($past(opFlagSel)));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Flag set wrong");

  property p_flag_clear;
    (cleanOp && opCode == srf_pkg::OP_FLAG_CLEAR) |=>
      statusFlags == ($past(flags_q) & ~srf_pkg::srf_bit_mask($past(opFlagSel)));
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag clear wrong");

  property p_sleep;
    // A second sleep taken at once keeps the pulse up legally.
    (cleanOp && opCode == srf_pkg::OP_SLEEP) |=> sleepReq && $stable(statusFlags) ##1
      (!sleepReq || $past(opAccept && opCode == srf_pkg::OP_SLEEP));
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep request wrong");

  property p_wdt;
    (cleanOp && opCode == srf_pkg::OP_WATCHDOG_RESTART) |=> watchdogRestart && $stable(statusFlags);
  endproperty
  a_wdt: assert property (p_wdt) else $error("Watchdog restart wrong");

  property p_break;
    // A software flag write in the break cycle may change the flags on its own.
    debugBreak |-> $past(opCode) == srf_pkg::OP_DEBUG_BREAK &&
      ($stable(statusFlags) || $past(link.regWrEn));
  endproperty
  a_break: assert property (p_break) else $error("Debug break wrong");

  c_io_clear: cover property (opAccept && opCode == srf_pkg::OP_IO_BIT_CLEAR ##2 ioWrEn);
  c_rotate: cover property (cleanOp && opCode == srf_pkg::OP_ROTATE_LEFT_CARRY);
  c_flag_set: cover property (cleanOp && opCode == srf_pkg::OP_FLAG_SET);
  c_sw_write: cover property (link.regWrEn && opAccept);
endmodule : srf_shift_rotate_flag_unit
`default_nettype wire

// >>> tb/srf_core_partner.sv
// Register file and I/O space model that takes the write-backs of the unit.
`timescale 1ns/1ps
`default_nettype none
module srf_core_partner (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       rfWrEn,
  input  wire logic [7:0] rfWrData,
  input  wire logic       ioWrEn,
  input  wire logic [5:0] ioWrAddr,
  input  wire logic [7:0] ioWrData,
  output var  logic [7:0] rfLast,
  output var  logic [7:0] ioLast,
  output var  int         ioCount
);
  // Stores each strobed write and counts I/O writes, so a doubled strobe shows.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rfLast <= 8'h00;
      ioLast <= 8'h00;
      ioCount <= 0;
    end else begin
      if (rfWrEn) rfLast <= rfWrData;
      if (ioWrEn) begin
        ioLast <= ioWrData;
        ioCount <= ioCount + 1;
      end
    end
  end
endmodule : srf_core_partner
`default_nettype wire

// >>> tb/srf_shift_rotate_flag_unit_bench.sv
// Self-checking bench of the shift, rotate and flag unit.
`timescale 1ns/1ps
`default_nettype none
module srf_shift_rotate_flag_unit_bench;
  logic             ref_clk, reset_n, psel, penable, pwrite, opValid, err;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             pready, pslverr, opReady, rfWrEn, ioWrEn;
  logic             sleepReq, watchdogRestart, debugBreak;
  srf_pkg::srf_op_e opCode;
  logic [2:0]       opBitSel, opFlagSel;
  logic [7:0]       regOperand, ioOperand, rfWrData, ioWrData, statusFlags;
  logic [7:0]       rfLast, ioLast, expFlags, r;
  logic [5:0]       ioAddr, ioWrAddr;
  int               n_errors, n_tests, ioCount, c0;
  // Operation tables walked by the loops below.
  srf_pkg::srf_op_e shOps [5] = '{srf_pkg::OP_LOGICAL_LEFT_SHIFT,
    srf_pkg::OP_LOGICAL_RIGHT_SHIFT, srf_pkg::OP_ROTATE_LEFT_CARRY,
    srf_pkg::OP_ROTATE_RIGHT_CARRY, srf_pkg::OP_ARITH_RIGHT_SHIFT};
  srf_pkg::srf_op_e ctlOps [4] = '{srf_pkg::OP_SLEEP, srf_pkg::OP_WATCHDOG_RESTART,
    srf_pkg::OP_DEBUG_BREAK, srf_pkg::OP_NOP};
  logic [7:0]       vals [4] = '{8'h81, 8'h00, 8'h7E, 8'hC1};

  srf_shift_rotate_flag_unit dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .opValid, .opCode, .opBitSel, .opFlagSel,
    .regOperand, .ioOperand, .ioAddr, .opReady, .rfWrEn, .rfWrData, .ioWrEn, .ioWrAddr,
    .ioWrData, .statusFlags, .sleepReq, .watchdogRestart, .debugBreak);

  srf_core_partner partner (.ref_clk, .reset_n, .rfWrEn, .rfWrData, .ioWrEn, .ioWrAddr,
    .ioWrData, .rfLast, .ioLast, .ioCount);

  // Clock of 4 ns period.
  always #2 ref_clk = ~ref_clk;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the edge with pready high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Lets the write that landed at this edge show on the flags.
    #1;
  endtask : apb

  // Offers one operation, holds it until taken, then lets the results settle.
  task automatic op(input srf_pkg::srf_op_e c, input logic [2:0] b, input logic [7:0] v);
    @(posedge ref_clk);
    opValid <= 1'b1;
    opCode <= c;
    opBitSel <= b;
    opFlagSel <= b;
    regOperand <= v;
    ioOperand <= v;
    do @(posedge ref_clk); while (opReady !== 1'b1);
    opValid <= 1'b0;
    #1;
  endtask : op

  // Expected shift result; also updates the expected Z, C, N and V flags.
  function automatic logic [7:0] calc(input srf_pkg::srf_op_e c, input logic [7:0] v);
    logic ci;
    ci = expFlags[0];
    case (c)
      srf_pkg::OP_LOGICAL_LEFT_SHIFT:  calc = {v[6:0], 1'b0};
      srf_pkg::OP_LOGICAL_RIGHT_SHIFT: calc = {1'b0, v[7:1]};
      srf_pkg::OP_ROTATE_LEFT_CARRY:   calc = {v[6:0], ci};
      srf_pkg::OP_ROTATE_RIGHT_CARRY:  calc = {ci, v[7:1]};
      default:                         calc = {v[7], v[7:1]};
    endcase
    expFlags[0] = (c == srf_pkg::OP_LOGICAL_LEFT_SHIFT ||
                   c == srf_pkg::OP_ROTATE_LEFT_CARRY) ? v[7] : v[0];
    expFlags[1] = (calc == 8'h00);
    expFlags[2] = calc[7];
    expFlags[3] = calc[7] ^ expFlags[0];
  endfunction : calc

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #40000;
    n_errors++;
    tally_and_finish();
  end

  // Main sequence of tests.
  initial begin
    {ref_clk, reset_n, psel, penable, pwrite, opValid} = 6'h00;
    {paddr, pwdata, opBitSel, opFlagSel, regOperand, ioOperand} = 0;
    opCode = srf_pkg::OP_NOP;
    ioAddr = 6'h15;
    n_errors = 0;
    n_tests = 0;
    expFlags = 8'h00;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Every flag is set alone, then cleared alone.
    for (int i = 0; i < 8; i++) begin
      op(srf_pkg::OP_FLAG_SET, i[2:0], 8'h00);
      expFlags[i] = 1'b1;
      chk(statusFlags, expFlags);
    end
    for (int i = 0; i < 8; i++) begin
      op(srf_pkg::OP_FLAG_CLEAR, i[2:0], 8'h00);
      expFlags[i] = 1'b0;
      chk(statusFlags, expFlags);
    end
    $display("flag set and clear test done");
    // Every shift and rotate over awkward operands, the carry carried along.
    foreach (shOps[k]) begin
      foreach (vals[j]) begin
        r = calc(shOps[k], vals[j]);
        op(shOps[k], 3'h0, vals[j]);
        chk({rfWrEn, rfWrData}, {1'b1, r});
        chk(statusFlags, expFlags);
      end
    end
    $display("shift and rotate test done");
    // Nibble swap and bit transfer through the transfer flag.
    op(srf_pkg::OP_NIBBLE_SWAP, 3'h0, 8'hA5);
    chk({rfWrData, statusFlags}, {8'h5A, expFlags});
    op(srf_pkg::OP_BIT_TO_TRANSFER_FLAG, 3'h3, 8'h08);
    expFlags[6] = 1'b1;
    chk(statusFlags, expFlags);
    op(srf_pkg::OP_TRANSFER_FLAG_TO_BIT, 3'h5, 8'h00);
    chk({rfWrData, statusFlags}, {8'h20, expFlags});
    op(srf_pkg::OP_BIT_TO_TRANSFER_FLAG, 3'h2, 8'h08);
    expFlags[6] = 1'b0;
    chk(statusFlags, expFlags);
    op(srf_pkg::OP_TRANSFER_FLAG_TO_BIT, 3'h0, 8'hFF);
    chk({rfWrData, statusFlags}, {8'hFE, expFlags});
    $display("swap and bit transfer test done");
    // I/O bit clear lands after the second edge, once.
    c0 = ioCount;
    op(srf_pkg::OP_IO_BIT_CLEAR, 3'h2, 8'hFF);
    chk({ioWrEn, opReady}, 2'b00);
    @(posedge ref_clk);
    #1;
    chk({ioWrEn, ioWrAddr, ioWrData}, {1'b1, 6'h15, 8'hFB});
    chk(statusFlags, expFlags);
    @(posedge ref_clk);
    #1;
    chk(ioCount, c0 + 1);
    chk(ioLast, 8'hFB);
    $display("I/O bit clear test done");
    // Control operations pulse their own line, the no operation none, and all keep the flags.
    foreach (ctlOps[k]) begin
      op(ctlOps[k], 3'h0, 8'h00);
      chk({sleepReq, watchdogRestart, debugBreak}, 3'b100 >> k);
      chk(statusFlags, expFlags);
    end
    $display("control operation test done");
    // Flag register over APB, status register and an unmapped address.
    apb(1'b1, 12'h000, 32'h000000C3);
    chk(statusFlags, 8'hC3);
    apb(1'b0, 12'h000, 32'h00000000);
    chk({err, rd}, {1'b0, 32'h000000C3});
    // A swap leaves its code as the last operation and keeps the flags.
    op(srf_pkg::OP_NIBBLE_SWAP, 3'h0, 8'h0F);
    chk({rfWrEn, rfWrData, statusFlags}, {1'b1, 8'hF0, 8'hC3});
    apb(1'b0, 12'h004, 32'h00000000);
    chk({err, rd}, {1'b0, 28'h0000000, 4'(srf_pkg::OP_NIBBLE_SWAP)});
    apb(1'b0, 12'h008, 32'h00000000);
    chk({err, rd}, {1'b1, 32'h00000000});
    $display("register access test done");
    tally_and_finish();
  end
endmodule : srf_shift_rotate_flag_unit_bench
`default_nettype wire
